// ==== bench/sfi_flash_tb.sv ====
/* Bench joining the host and flash ends over the link interface.
   Assumes the design files and the link checker are compiled first. */
`timescale 1ns/1ps
module sfi_flash_tb;
    localparam logic [7:0] MF = 8'hA5, DV = 8'h3C, TY = 8'h21, CP = 8'h0E; // Arbitrary values
    logic clk = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, cmd_swap = 1'h0, dev_in_pd = 1'h0;
    logic enter_pd = 1'h0, pe_busy = 1'h0, sw_busy = 1'h0;
    logic cmd_ready, rsp_valid, rsp_refused, write_ok, pd_active, write_allowed;
    sfi_pkg::sfi_cmd_t cmd_kind = sfi_pkg::CMD_WAKE;
    logic [23:0] rsp_data;
    logic [7:0] status_value;
    logic [24:0] exp_q[$];
    int n_errors = 0, n_checks = 0, cycles = 0;
    sfi_link_if lnk();
    sfi_flash_dev #(.MFR_ID(MF), .DEV_ID(DV), .MEM_TYPE(TY), .CAPACITY(CP), .PUW_CYCLES(50))
    i_sfi_flash_dev (.clk(clk), .rst_n(rst_n), .lnk(lnk.dev), .enter_pd(enter_pd),
        .prog_erase_busy(pe_busy), .status_write_busy(sw_busy), .pd_active(pd_active),
        .write_allowed(write_allowed), .status_value(status_value));
    sfi_flash_host #(.PUW_CYCLES(50)) i_sfi_flash_host (.clk(clk), .rst_n(rst_n),
        .lnk(lnk.host), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_swap(cmd_swap),
        .cmd_ready(cmd_ready), .dev_in_pd(dev_in_pd), .rsp_valid(rsp_valid),
        .rsp_refused(rsp_refused), .rsp_data(rsp_data), .write_ok(write_ok));
    sfi_link_asserts i_sfi_link_asserts (.clk(clk), .rst_n(rst_n), .cs_n(lnk.cs_n),
        .sclk(lnk.sclk), .mosi(lnk.mosi), .miso_o(lnk.miso_o), .miso_oe_n(lnk.miso_oe_n),
        .miso(lnk.miso));
    always #5 clk = ~clk;
    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask: check
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask: complete_run
    // Bytes read back; an ignored instruction reads the pulled-up line
    function automatic logic [24:0] rsp_of(sfi_pkg::sfi_cmd_t k, logic sw, logic dead);
        case (k)
            sfi_pkg::CMD_LEGACY_ID: return dead ? 25'h00000FF : {17'h00000, DV};
            sfi_pkg::CMD_MFR_ID: return dead ? 25'h000FFFF : {9'h000, sw ? {DV, MF} : {MF, DV}};
            sfi_pkg::CMD_IDENT: return dead ? 25'h0FFFFFF : {1'h0, MF, TY, CP};
            default: return 25'h0000000;
        endcase
    endfunction: rsp_of
    task automatic send(input sfi_pkg::sfi_cmd_t k, input logic sw, input logic [24:0] e);
        @(negedge clk);
        cmd_valid = 1'h1;
        cmd_kind = k;
        cmd_swap = sw;
        while (cmd_ready !== 1'h1) @(negedge clk);
        @(posedge clk);
        exp_q.push_back(e);
    endtask: send
    task automatic drain(input int extra);
        @(negedge clk);
        cmd_valid = 1'h0;
        while (exp_q.size() != 0) @(negedge clk);
        repeat (extra) @(negedge clk);
    endtask: drain
    task automatic pd_pulse();
        @(negedge clk);
        enter_pd = 1'h1;
        @(negedge clk);
        enter_pd = 1'h0;
        check({24'h000000, pd_active}, 25'h0000001);
    endtask: pd_pulse
    always @(negedge clk) begin
        if (rsp_valid === 1'h1 || rsp_refused === 1'h1) begin
            check({rsp_refused, rsp_refused ? 24'h000000 : rsp_data},
                exp_q.size() != 0 ? exp_q.pop_front() : 25'h1FFFFFF);
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        logic sw;
        void'($urandom(81804));
        repeat (2) @(negedge clk);
        rst_n = 1'h1;
        repeat (6) @(negedge clk);
        check({15'h0000, write_allowed, write_ok, status_value}, 25'h0000000);
        // Every kind from standby, twelve back to back so the FIFO fills
        for (int i = 0; i < 12; i++) begin
            sw = (i < 4) ? 1'h0 : (i < 8) ? 1'h1 : 1'($urandom_range(1, 0));
            send(sfi_pkg::sfi_cmd_t'(2'(i)), sw, rsp_of(sfi_pkg::sfi_cmd_t'(2'(i)), sw, 1'h0));
        end
        drain(20);
        check({15'h0000, write_allowed, write_ok, status_value}, 25'h0000300);
        pd_pulse();
        dev_in_pd = 1'h1;
        send(sfi_pkg::CMD_IDENT, 1'h0, 25'h1000000);
        drain(2);
        dev_in_pd = 1'h0;
        send(sfi_pkg::CMD_MFR_ID, 1'h0, rsp_of(sfi_pkg::CMD_MFR_ID, 1'h0, 1'h1));
        send(sfi_pkg::CMD_WAKE, 1'h0, 25'h0000000);
        drain(250);
        check({24'h000000, pd_active}, 25'h0000001);
        repeat (70) @(negedge clk);
        check({24'h000000, pd_active}, 25'h0000000);
        pd_pulse();
        send(sfi_pkg::CMD_LEGACY_ID, 1'h0, {17'h00000, DV});
        drain(150);
        check({24'h000000, pd_active}, 25'h0000001);
        repeat (50) @(negedge clk);
        check({24'h000000, pd_active}, 25'h0000000);
        pe_busy = 1'h1;
        send(sfi_pkg::CMD_IDENT, 1'h0, rsp_of(sfi_pkg::CMD_IDENT, 1'h0, 1'h1));
        send(sfi_pkg::CMD_LEGACY_ID, 1'h0, 25'h00000FF);
        drain(5);
        pe_busy = 1'h0;
        sw_busy = 1'h1;
        send(sfi_pkg::CMD_LEGACY_ID, 1'h0, 25'h00000FF);
        send(sfi_pkg::CMD_IDENT, 1'h0, rsp_of(sfi_pkg::CMD_IDENT, 1'h0, 1'h0));
        drain(5);
        sw_busy = 1'h0;
        complete_run();
    end
endmodule: sfi_flash_tb

// ==== bench/sfi_link_asserts.sv ====
/* Checker on the link wires between the host and flash ends.
   Assumes the wires are sampled on the shared 100 MHz clock. */
`timescale 1ns/1ps
module sfi_link_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link wires
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n,
    input wire logic miso
);
    logic sclk_reg;
    logic [5:0] bits_reg;
    logic [9:0] gap_reg;
    // Clock rises in the current frame, idle cycles before the next selection
    wire sclk_rise = sclk && !sclk_reg && !cs_n;
    wire frame_start = !cs_n && gap_reg != 10'h000;
    wire [5:0] bits_next = frame_start ? {5'h00, sclk_rise} : bits_reg + {5'h00, sclk_rise};
    wire [9:0] gap_next = !cs_n ? 10'h000 : gap_reg + {9'h000, gap_reg != 10'h3FF};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_reg <= 1'h0;
            bits_reg <= 6'h00;
            gap_reg <= 10'h000;
        end else begin
            sclk_reg <= sclk;
            bits_reg <= bits_next;
            gap_reg <= gap_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("serial clock not low while deselected");
    a_mosi_on_low: assert property ($changed(mosi) |-> !sclk)
        else $error("host data changed while clock high");
    a_miso_on_low: assert property (!miso_oe_n && $changed(miso_o) |-> !sclk)
        else $error("flash data changed while clock high");
    a_release_desel: assert property ($rose(cs_n) |-> ##[1:5] miso_oe_n)
        else $error("flash output not released after deselect");
    a_quiet_idle: assert property (cs_n [*6] |-> miso_oe_n && miso)
        else $error("flash drives while deselected");
    a_drive_after_cmd: assert property ($fell(miso_oe_n) |-> bits_reg inside {6'h08, 6'h20})
        else $error("flash drives before its input bits were taken");
    a_frame_len: assert property ($rose(cs_n) |-> bits_reg inside {6'h08, 6'h20, 6'h28, 6'h30})
        else $error("frame length not a whole instruction");
    a_wake_gap: assert property ($fell(cs_n) && bits_reg == 6'h08 |-> gap_reg >= 10'h12C)
        else $error("reselected inside the wake delay");
    a_id_gap: assert property ($fell(cs_n) && bits_reg == 6'h28 |-> gap_reg >= 10'h0B4)
        else $error("reselected inside the delay after an id read");
endmodule: sfi_link_asserts

// ==== verilog/sfi_fifo.sv ====
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock; ready and valid outputs are registered.
 */
`timescale 1ns/1ps

module sfi_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;

    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;
    wire [AW:0] count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

    assign out_data = mem[rd_ptr_reg];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready <= 1'h0;
            out_valid <= 1'h0;
        end else begin
            wr_ptr_reg <= push ? AW'((wr_ptr_reg + 1) % DEPTH) : wr_ptr_reg;
            rd_ptr_reg <= pop ? AW'((rd_ptr_reg + 1) % DEPTH) : rd_ptr_reg;
            count_reg <= count_next;
            in_ready <= count_next != (AW+1)'(DEPTH);
            out_valid <= count_next != '0;
        end
    end
endmodule: sfi_fifo

// ==== verilog/sfi_flash_dev.sv ====
/*
 * Flash end of the link: wake from deep power-down and the three
 * identification instructions, release delays, power-up write delay.
 * Assumes the rest of the flash reports its write cycles and requests
 * deep power-down; link pins are asynchronous to clk.
 */
`timescale 1ns/1ps
`include "sfi_params.svh"

module sfi_flash_dev #(
    parameter logic [7:0] MFR_ID = 8'h5A,   // Arbitrary value
    parameter logic [7:0] DEV_ID = 8'h12,   // Arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h30, // Arbitrary value
    parameter logic [7:0] CAPACITY = 8'h13, // Arbitrary value
    parameter int PUW_CYCLES = `SFI_PUW_MIN_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    sfi_link_if.dev lnk,
    // Rest of the flash
    input wire logic enter_pd,
    input wire logic prog_erase_busy,
    input wire logic status_write_busy,
    // Status towards the rest of the flash
    output logic pd_active,
    output logic write_allowed,
    output logic [7:0] status_value
);
    localparam int PUW_W = $clog2(PUW_CYCLES + 1);
    localparam logic [9:0] WAKE_ONLY_CYC = 10'(`SFI_WAKE_ONLY_CYC);
    localparam logic [9:0] WAKE_ID_CYC = 10'(`SFI_WAKE_AFTER_ID_CYC);

    // Synchronisers and edge history
    logic [1:0] cs_sync_reg;
    logic [1:0] sclk_sync_reg;
    logic [1:0] mosi_sync_reg;
    logic cs_prev_reg;
    logic sclk_prev_reg;

    // Instruction engine
    sfi_pkg::sfi_dev_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [1:0] byte_cnt_reg;
    logic [7:0] shin_reg;
    logic [7:0] opc_reg;
    logic [23:0] shout_reg;
    logic miso_reg;
    logic miso_oe_n_reg;

    // Power state
    logic pd_reg;
    logic wake_from_pd_reg;
    logic [9:0] wake_cnt_reg;
    logic [PUW_W-1:0] pu_cnt_reg;
    logic write_allowed_reg;
    logic [7:0] status_reg;

    // Edges seen through the synchronisers
    wire cs_s = cs_sync_reg[1];
    wire sclk_s = sclk_sync_reg[1];
    wire mosi_s = mosi_sync_reg[1];
    wire cs_fall = ~cs_s & cs_prev_reg;
    wire cs_rise = cs_s & ~cs_prev_reg;
    wire sclk_rise = sclk_s & ~sclk_prev_reg & ~cs_s;
    wire sclk_fall = ~sclk_s & sclk_prev_reg & ~cs_s;

    // Serial input assembly
    wire shifting = (state_reg == sfi_pkg::DEV_OPCODE) || (state_reg == sfi_pkg::DEV_ADDR);
    wire [7:0] byte_in = {shin_reg[6:0], mosi_s};
    wire byte_end = sclk_rise & shifting & (bit_cnt_reg == 3'h7);
    wire opc_end = byte_end & (state_reg == sfi_pkg::DEV_OPCODE);
    wire addr_end = byte_end & (state_reg == sfi_pkg::DEV_ADDR) & (byte_cnt_reg == 2'h2);

    // Opcode decode
    wire wr_busy = prog_erase_busy | status_write_busy;
    wire waking = wake_cnt_reg != 10'h000;
    wire accept_wake = (byte_in == `SFI_OP_WAKE_ID) & ~wr_busy;
    wire accept_mfr = (byte_in == `SFI_OP_MFR_DEV) & ~pd_reg;
    wire accept_ident = (byte_in == `SFI_OP_IDENT) & ~pd_reg & ~prog_erase_busy;
    wire sfi_pkg::sfi_dev_state_t opc_state = accept_ident ? sfi_pkg::DEV_OUT :
        (accept_wake | accept_mfr) ? sfi_pkg::DEV_ADDR : sfi_pkg::DEV_IGNORE;

    // Output words, rotated so each repeats while clocks continue
    wire [23:0] ident_word = {MFR_ID, MEM_TYPE, CAPACITY};
    wire [23:0] legacy_word = {DEV_ID, DEV_ID, DEV_ID};
    wire [23:0] mfr_word = byte_in[0] ? {DEV_ID, MFR_ID, DEV_ID} :
        {MFR_ID, DEV_ID, MFR_ID};
    wire [23:0] addr_word = (opc_reg == `SFI_OP_WAKE_ID) ? legacy_word : mfr_word;
    wire [9:0] wake_load = (state_reg == sfi_pkg::DEV_OUT) ? WAKE_ID_CYC : WAKE_ONLY_CYC;

    assign lnk.miso_o = miso_reg;
    assign lnk.miso_oe_n = miso_oe_n_reg;
    assign pd_active = pd_reg;
    assign write_allowed = write_allowed_reg;
    assign status_value = status_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_sync_reg <= 2'h3;
            sclk_sync_reg <= 2'h0;
            mosi_sync_reg <= 2'h0;
            cs_prev_reg <= 1'h1;
            sclk_prev_reg <= 1'h0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], lnk.cs_n};
            sclk_sync_reg <= {sclk_sync_reg[0], lnk.sclk};
            mosi_sync_reg <= {mosi_sync_reg[0], lnk.mosi};
            cs_prev_reg <= cs_s;
            sclk_prev_reg <= sclk_s;
        end
    end

    // Instruction sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= sfi_pkg::DEV_IDLE;
        end else if (cs_rise) begin
            state_reg <= sfi_pkg::DEV_IDLE;
        end else if (cs_fall) begin
            state_reg <= waking ? sfi_pkg::DEV_IGNORE : sfi_pkg::DEV_OPCODE;
        end else begin
            case (state_reg)
                sfi_pkg::DEV_OPCODE: begin
                    state_reg <= opc_end ? opc_state : state_reg;
                end
                sfi_pkg::DEV_ADDR: begin
                    state_reg <= addr_end ? sfi_pkg::DEV_OUT : state_reg;
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // Bit and byte counting from the select edge, MSB first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 2'h0;
            shin_reg <= 8'h00;
            opc_reg <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 2'h0;
        end else if (sclk_rise && shifting) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shin_reg <= byte_in;
            if (byte_end && state_reg == sfi_pkg::DEV_ADDR) begin
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
            end
            if (opc_end) begin
                opc_reg <= byte_in;
            end
        end
    end

    // Serial output on falling clock edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shout_reg <= 24'h000000;
            miso_reg <= 1'h0;
            miso_oe_n_reg <= 1'h1;
        end else begin
            if (opc_end && accept_ident) begin
                shout_reg <= ident_word;
            end else if (addr_end) begin
                shout_reg <= addr_word;
            end else if (sclk_fall && state_reg == sfi_pkg::DEV_OUT) begin
                shout_reg <= {shout_reg[22:0], shout_reg[23]};
            end
            if (sclk_fall && state_reg == sfi_pkg::DEV_OUT) begin
                miso_reg <= shout_reg[23];
            end
            if (cs_s || state_reg != sfi_pkg::DEV_OUT) begin
                miso_oe_n_reg <= 1'h1;
            end else if (sclk_fall) begin
                miso_oe_n_reg <= 1'h0;
            end
        end
    end

    // Deep power-down and release delays
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_reg <= 1'h0;
            wake_from_pd_reg <= 1'h0;
            wake_cnt_reg <= 10'h000;
        end else begin
            if (enter_pd) begin
                pd_reg <= 1'h1;
            end else if (wake_cnt_reg == 10'h001) begin
                pd_reg <= 1'h0;
            end
            if (cs_fall) begin
                wake_from_pd_reg <= 1'h0;
            end else if (opc_end && accept_wake) begin
                wake_from_pd_reg <= pd_reg;
            end
            if (enter_pd) begin
                wake_cnt_reg <= 10'h000;
            end else if (cs_rise && wake_from_pd_reg) begin
                wake_cnt_reg <= wake_load;
            end else if (waking) begin
                wake_cnt_reg <= wake_cnt_reg - 10'h001;
            end
        end
    end
    // A release from standby loads no delay, so the next select is served.

    // Power-up write inhibit and delivery status
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_cnt_reg <= PUW_W'(PUW_CYCLES);
            write_allowed_reg <= 1'h0;
            status_reg <= `SFI_STATUS_RESET;
        end else begin
            if (pu_cnt_reg != '0) begin
                pu_cnt_reg <= pu_cnt_reg - PUW_W'(1);
            end
            write_allowed_reg <= (pu_cnt_reg == '0);
            status_reg <= status_reg;
        end
    end
endmodule: sfi_flash_dev

// ==== verilog/sfi_flash_host.sv ====
/*
 * Host end of the link: takes queued identification and wake commands,
 * generates select and serial clock, and returns the bytes read.
 * Assumes user logic on the same clock; the data out pin is asynchronous.
 */
`timescale 1ns/1ps
`include "sfi_params.svh"

module sfi_flash_host #(
    parameter int HALF = `SFI_SCLK_HALF,
    parameter int FIFO_DEPTH = 8,
    parameter int PUW_CYCLES = `SFI_PUW_MAX_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link
    sfi_link_if.host lnk,
    // Command side
    input wire logic cmd_valid,
    input wire sfi_pkg::sfi_cmd_t cmd_kind,
    input wire logic cmd_swap,
    output logic cmd_ready,
    input wire logic dev_in_pd,
    // Answer side
    output logic rsp_valid,
    output logic rsp_refused,
    output logic [23:0] rsp_data,
    output logic write_ok
);
    localparam int PUW_W = $clog2(PUW_CYCLES + 1);
    localparam int DW = $clog2(HALF);

    sfi_pkg::sfi_host_state_t state_reg;
    sfi_pkg::sfi_cmd_t kind_reg;
    sfi_pkg::sfi_cmd_word_t fifo_out;
    logic fifo_valid;
    logic [1:0] miso_sync_reg;
    logic [DW-1:0] div_reg;
    logic [5:0] bit_cnt_reg;
    logic [31:0] tx_reg;
    logic [23:0] rx_reg;
    logic [9:0] gap_reg;
    logic [PUW_W-1:0] pu_cnt_reg;
    logic cs_n_reg;
    logic sclk_reg;
    logic mosi_reg;

    wire idle = state_reg == sfi_pkg::HOST_IDLE;
    wire sfi_pkg::sfi_cmd_t k = fifo_out.kind;
    wire refuse = fifo_out.kind == sfi_pkg::CMD_IDENT && dev_in_pd;
    wire start = idle & fifo_valid & ~refuse;
    wire [31:0] tx_word = (k == sfi_pkg::CMD_MFR_ID) ? {`SFI_OP_MFR_DEV, 23'h000000, fifo_out.swap} :
        (k == sfi_pkg::CMD_IDENT) ? {`SFI_OP_IDENT, 24'h000000} : {`SFI_OP_WAKE_ID, 24'h000000};
    wire [5:0] last_bit = (kind_reg == sfi_pkg::CMD_WAKE) ? 6'h07 :
        (kind_reg == sfi_pkg::CMD_LEGACY_ID) ? 6'h27 :
        (kind_reg == sfi_pkg::CMD_MFR_ID) ? 6'h2F : 6'h1F;
    wire [5:0] rx_first = (kind_reg == sfi_pkg::CMD_IDENT) ? 6'h08 : 6'h20;
    wire tick = div_reg == DW'(HALF - 1);
    wire end_xfer = tick & sclk_reg & (bit_cnt_reg == last_bit);
    wire [9:0] gap_load = (kind_reg == sfi_pkg::CMD_WAKE) ? 10'(`SFI_WAKE_ONLY_WAIT_CYC) :
        (kind_reg == sfi_pkg::CMD_LEGACY_ID) ? 10'(`SFI_WAKE_ID_WAIT_CYC) :
        10'(`SFI_CS_HIGH_CYC);

    sfi_fifo #(.WIDTH(3), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_kind, cmd_swap}),
        .out_valid(fifo_valid),
        .out_ready(idle),
        .out_data(fifo_out)
    );

    assign lnk.cs_n = cs_n_reg;
    assign lnk.sclk = sclk_reg;
    assign lnk.mosi = mosi_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= sfi_pkg::HOST_IDLE;
            kind_reg <= sfi_pkg::CMD_WAKE;
            miso_sync_reg <= 2'h0;
            div_reg <= '0;
            bit_cnt_reg <= 6'h00;
            tx_reg <= 32'h00000000;
            rx_reg <= 24'h000000;
            gap_reg <= 10'h000;
            cs_n_reg <= 1'h1;
            sclk_reg <= 1'h0;
            mosi_reg <= 1'h0;
            rsp_valid <= 1'h0;
            rsp_refused <= 1'h0;
            rsp_data <= 24'h000000;
        end else begin
            miso_sync_reg <= {miso_sync_reg[0], lnk.miso};
            rsp_valid <= 1'h0;
            rsp_refused <= idle & fifo_valid & refuse;
            case (state_reg)
                sfi_pkg::HOST_IDLE: begin
                    if (start) begin
                        state_reg <= sfi_pkg::HOST_XFER;
                        kind_reg <= k;
                        tx_reg <= tx_word;
                        mosi_reg <= tx_word[31];
                        cs_n_reg <= 1'h0;
                        div_reg <= '0;
                        bit_cnt_reg <= 6'h00;
                        rx_reg <= 24'h000000;
                    end
                end
                sfi_pkg::HOST_XFER: begin
                    div_reg <= tick ? '0 : div_reg + DW'(1);
                    if (tick && !sclk_reg) begin
                        sclk_reg <= 1'h1;
                        if (bit_cnt_reg >= rx_first) begin
                            rx_reg <= {rx_reg[22:0], miso_sync_reg[1]};
                        end
                    end else if (end_xfer) begin
                        sclk_reg <= 1'h0;
                        cs_n_reg <= 1'h1;
                        gap_reg <= gap_load;
                        state_reg <= sfi_pkg::HOST_GAP;
                        rsp_valid <= 1'h1;
                        rsp_data <= rx_reg;
                    end else if (tick) begin
                        sclk_reg <= 1'h0;
                        bit_cnt_reg <= bit_cnt_reg + 6'h01;
                        tx_reg <= {tx_reg[30:0], 1'h0};
                        mosi_reg <= tx_reg[30];
                    end
                end
                sfi_pkg::HOST_GAP: begin
                    gap_reg <= gap_reg - 10'h001;
                    if (gap_reg <= 10'h001) begin
                        state_reg <= sfi_pkg::HOST_IDLE;
                    end
                end
                default: begin
                    state_reg <= sfi_pkg::HOST_IDLE;
                end
            endcase
        end
    end

    // Writes are allowed only after the longest power-up delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pu_cnt_reg <= PUW_W'(PUW_CYCLES);
            write_ok <= 1'h0;
        end else begin
            if (pu_cnt_reg != '0) begin
                pu_cnt_reg <= pu_cnt_reg - PUW_W'(1);
            end
            write_ok <= (pu_cnt_reg == '0);
        end
    end
endmodule: sfi_flash_host

// ==== verilog/sfi_link_if.sv ====
/*
 * Serial link between host and flash: select, clock, data in, data out.
 * Assumes the data out wire floats high (pull-up) when the flash lets go.
 */
`timescale 1ns/1ps

interface sfi_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    wire miso;

    // Pull-up when the flash does not drive
    assign miso = miso_oe_n ? 1'h1 : miso_o;

    modport dev(input cs_n, input sclk, input mosi, input miso, output miso_o, output miso_oe_n);
    modport host(output cs_n, output sclk, output mosi, input miso);
endinterface: sfi_link_if

// ==== verilog/sfi_params.svh ====
/*
 * Constants of the serial flash identification and wake logic: opcodes,
 * timing figures and the cycle counts derived from them, reset values.
 * Assumes a 100 MHz system clock on both ends of the link.
 */
`ifndef SFI_PARAMS_SVH
`define SFI_PARAMS_SVH

`define SFI_CLK_PERIOD_NS 10
`define SFI_NS_PER_MS 1000000

// Opcodes
`define SFI_OP_WAKE_ID 8'hAB
`define SFI_OP_MFR_DEV 8'h90
`define SFI_OP_IDENT 8'h9F

// Link timing in ns, then in system clock cycles
`define SFI_WAKE_ONLY_NS 3000
`define SFI_WAKE_AFTER_ID_NS 1800
`define SFI_CS_HIGH_MIN_NS 100
`define SFI_WAKE_ONLY_CYC (`SFI_WAKE_ONLY_NS / `SFI_CLK_PERIOD_NS)
`define SFI_WAKE_AFTER_ID_CYC (`SFI_WAKE_AFTER_ID_NS / `SFI_CLK_PERIOD_NS)
`define SFI_WAKE_ONLY_WAIT_CYC ((`SFI_WAKE_ONLY_NS + `SFI_CLK_PERIOD_NS - 1) / `SFI_CLK_PERIOD_NS)
`define SFI_WAKE_ID_WAIT_CYC ((`SFI_WAKE_AFTER_ID_NS + `SFI_CLK_PERIOD_NS - 1) / `SFI_CLK_PERIOD_NS)
`define SFI_CS_HIGH_CYC ((`SFI_CS_HIGH_MIN_NS + `SFI_CLK_PERIOD_NS - 1) / `SFI_CLK_PERIOD_NS)

// Power-up write delay in ms, then in cycles
`define SFI_PUW_MIN_MS 1
`define SFI_PUW_MAX_MS 10
`define SFI_PUW_MIN_CYC (`SFI_PUW_MIN_MS * `SFI_NS_PER_MS / `SFI_CLK_PERIOD_NS)
`define SFI_PUW_MAX_CYC (`SFI_PUW_MAX_MS * `SFI_NS_PER_MS / `SFI_CLK_PERIOD_NS)

// Serial clock half period of the host, in cycles (160 ns period)
`define SFI_SCLK_HALF 8

// Delivery state
`define SFI_STATUS_RESET 8'h00
`define SFI_ARRAY_ERASED 8'hFF

`endif

// ==== verilog/sfi_pkg.sv ====
/*
 * Types shared by both ends of the identification and wake link.
 * Assumes nothing of its surroundings.
 */
package sfi_pkg;

    typedef enum logic [2:0] {DEV_IDLE, DEV_OPCODE, DEV_ADDR, DEV_OUT, DEV_IGNORE} sfi_dev_state_t;

    typedef enum logic [1:0] {HOST_IDLE, HOST_XFER, HOST_GAP} sfi_host_state_t;

    typedef enum logic [1:0] {CMD_WAKE, CMD_LEGACY_ID, CMD_MFR_ID, CMD_IDENT} sfi_cmd_t;

    typedef struct packed {
        sfi_cmd_t kind;
        logic swap;
    } sfi_cmd_word_t;

endpackage: sfi_pkg
